// ===== include/sleep_pkg.sv
/*
  Shared constants and types of the sleep controller and external interrupt.
  Assumes one 100 MHz clock that stands for the fast oscillator clock.
*/
package sleep_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG_ONE = 8'h00;
  localparam logic [7:0] OFS_CFG_TWO = 8'h04;
  localparam logic [7:0] OFS_EXT_ISC = 8'h08;
  localparam logic [7:0] OFS_BRK_STAT = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG1_SHORT_REC_BIT = 0;
  localparam int CFG1_WDOG_OFF_BIT = 1;
  localparam int CFG1_OSCKEEP_BIT = 2;
  localparam int CFG2_PIN_INT_BIT = 0;
  localparam int CFG2_RSTEN_BIT = 1;
  localparam int ISC_MODE_BIT = 0;
  localparam int ISC_MASK_BIT = 1;
  localparam int ISC_ACK_BIT = 2;
  localparam int ISC_FLAG_BIT = 3;
  localparam int BRK_FLAG_BIT = 1;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] CFG1_RESET = 3'h0;
  localparam logic [1:0] CFG2_RESET = 2'h0;
  localparam int NUM_SOURCES = 24;
  localparam int REC_LONG_CYC = 4096;
  localparam int REC_SHORT_CYC = 32;
  localparam logic [15:0] VEC_TOP = 16'hFFFA;
  typedef enum {ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER} lp_state_e;
  typedef struct packed {
    logic keep_osc_in_stop_bit;
    logic watchdog_disable_bit;
    logic short_stop_recovery_bit;
  } cfg_one_s;
  typedef struct packed {
    logic rst_pin_enable;
    logic ext_int_pin_enable;
  } cfg_two_s;
endpackage

// ===== rtl/ext_int_latch.sv
/*
  External interrupt pin latch with edge or edge-and-level sensing.
  Assumes the pin input is synchronous to MCLK.
*/
`timescale 1ns/100ps
module ext_int_latch (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic pin,
  input wire logic enable,
  input wire logic level_mode,
  input wire logic clear_vec,
  input wire logic clear_sw,
  output logic latched
);
  import sleep_pkg::*;

  logic pin_prev_reg;
  logic latch_reg;
  logic set_w;
  logic clr_w;

  // Falling edge always; low level only in level mode.
  assign set_w = enable && ((pin_prev_reg && !pin) || (level_mode && !pin));
  assign clr_w = clear_vec || clear_sw;
  assign latched = latch_reg;

  // A new edge in the clearing cycle is kept, so no request is lost.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pin_prev_reg <= 1'b1;
      latch_reg <= 1'b0; // RQ19
    end else begin
      pin_prev_reg <= pin;
      latch_reg <= set_w || (latch_reg && !clr_w); // RQ16 RQ20
    end
  end

  edge_set_a: assert property (@(posedge MCLK) disable iff (RST) // RQ20
    enable && $fell(pin) |=> latch_reg)
    else $error("falling edge did not set latch");
  clear_a: assert property (@(posedge MCLK) disable iff (RST) // RQ17
    clr_w && !set_w |=> !latch_reg)
    else $error("latch not cleared");
endmodule

// ===== rtl/recovery_counter.sv
/*
  Stop-recovery counter of the system integration unit.
  Assumes clear is held from stop entry until recovery starts.
*/
`timescale 1ns/100ps
module recovery_counter (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic clear,
  input wire logic short_sel,
  output logic done
);
  import sleep_pkg::*;

  logic [12:0] count_reg;
  logic [12:0] count_next;
  logic [12:0] target;
  logic done_reg;

  // Last count of the chosen delay; done fires on that cycle.
  assign target = short_sel ? 13'(REC_SHORT_CYC - 1) : 13'(REC_LONG_CYC - 1);
  assign count_next = (count_reg == target) ? count_reg : count_reg + 13'h1;
  assign done = done_reg;

  // Counter stays at zero while cleared, then runs once to target.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      count_reg <= 13'h0;
      done_reg <= 1'b0;
    end else if (clear) begin
      count_reg <= 13'h0; // RQ14
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next; // RQ12
      done_reg <= (count_next == target) && (count_reg != target);
    end
  end

  rec_len_a: assert property (@(posedge MCLK) disable iff (RST) // RQ12
    $rose(done) |-> $past(count_reg) == target - 13'h1)
    else $error("recovery done at wrong count");
endmodule

// ===== rtl/sleep_ctrl.sv
/*
  Sleep sequencer, clock divider, interrupt arbiter and external interrupt
  control with an APB register slave.
  Assumes MCLK is the fast oscillator clock and all inputs are synchronous.
*/
`timescale 1ns/100ps
// Function
// RQ1 - Divide fast clock by two, then two again for the bus clock.
// RQ2 - Reset and interrupt pins stay port bits until config two selects.
// RQ3 - Arbitrate up to 24 sources, acknowledge and generate vectors.
// RQ4 - Wait ends on reset, and on break in emulation mode.
// RQ5 - Break during wait sets the break stop/wait flag.
// RQ6 - Watchdog keeps running in wait unless disabled.
// RQ7 - Low-power exit is reset pin OR pending CPU interrupt.
// RQ8 - Stop entry clears the counter and disables system clocks.
// RQ9 - Stop ends on module interrupt, reset or break.
// RQ10 - Stacking after interrupt wake starts only after full recovery.
// RQ11 - Stop gates both clocks; fast clock kept if keep bit set.
// RQ12 - Recovery is 4096 fast cycles, or 32 with short bit set.
// RQ13 - Software with a crystal should keep the short bit clear.
// RQ14 - Counter held clear from stop until recovery, then times it.
// RQ15 - Pin enable bit zero disables the external interrupt function.
// RQ16 - Low pin sets latch; it holds until fetch, clear or reset.
// RQ17 - External vector fetch acknowledges and clears the latch.
// RQ18 - Writing one to the acknowledge bit clears the latch.
// RQ19 - Any reset clears the latch.
// RQ20 - Falling edge only after reset; mode bit adds low level.
// RQ21 - Latch is forwarded only when enabled and not masked.
module sleep_ctrl (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic WAIT_REQ,
  input wire logic STOP_REQ,
  input wire logic BREAK_REQ,
  input wire logic EMU_MODE,
  input wire logic RST_PIN_N,
  input wire logic EXT_INT_PIN_N,
  input wire logic [sleep_pkg::NUM_SOURCES-2:0] PERIPH_IRQ,
  input wire logic VECTOR_FETCH,
  output logic HALF_OSC_CLK,
  output logic BUS_CLK,
  output logic FAST_OSC_EN,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic WDOG_EN,
  output logic STACK_START,
  output logic INT_PENDING,
  output logic [15:0] INT_VECTOR,
  output logic [sleep_pkg::NUM_SOURCES-1:0] INT_ACK,
  output logic RST_PIN_FUNC,
  output logic EXT_INT_PIN_FUNC
);
  import sleep_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lp_state_e state_reg, state_next;
  cfg_one_s config_reg_one;
  cfg_two_s config_reg_two;
  logic isc_mode_reg, isc_mask_reg, stop_wait_flag_reg, int_cause_reg;
  logic pready_reg, pslverr_reg, stack_reg, half_reg, bus_reg;
  logic [31:0] prdata_reg;
  logic [15:0] vector_reg;
  logic [NUM_SOURCES-1:0] ack_reg;
  logic pending_reg, wdog_reg, fast_en_reg, cpu_en_reg, per_en_reg;
  logic ext_latched, ext_req, pin_reset, low_power_exit, rec_done;
  logic apb_wr, apb_rd_phase, addr_ok, sw_ack, emu_break, stack_next;
  logic [NUM_SOURCES-1:0] sources;
  logic [4:0] win_idx;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Arbitration helpers
  // ----------------------------------------------------------------
  // Lowest index wins; index zero is the external pin.
  function automatic logic [4:0] first_set(
      input logic [NUM_SOURCES-1:0] v);
    logic [4:0] r;
    r = 5'h0;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Each source owns one two-byte vector, counted down from the top.
  function automatic logic [15:0] vec_of(input logic [4:0] idx);
    return VEC_TOP - {10'h0, idx, 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // The acknowledge field is write-only; the latch flag and status bits are read-only; the break flag clears on a written zero.
  assign apb_wr = PSEL && PENABLE && pready_reg && PWRITE;
  assign apb_rd_phase = PSEL && PENABLE && !pready_reg;
  assign addr_ok = (PADDR == OFS_CFG_ONE) || (PADDR == OFS_CFG_TWO)
      || (PADDR == OFS_EXT_ISC) || (PADDR == OFS_BRK_STAT)
      || (PADDR == OFS_STATUS);
  assign sw_ack = apb_wr && (PADDR == OFS_EXT_ISC) && PWDATA[ISC_ACK_BIT];
  assign ext_req = ext_latched && config_reg_two.ext_int_pin_enable
      && !isc_mask_reg; // RQ21
  assign sources = {PERIPH_IRQ, ext_req}; // RQ3
  assign win_idx = first_set(sources);
  assign pin_reset = config_reg_two.rst_pin_enable && !RST_PIN_N;
  assign low_power_exit = pin_reset || (|sources); // RQ7
  assign emu_break = BREAK_REQ && EMU_MODE;

  // Read multiplexer; unmapped addresses read zero with an error.
  always_comb begin
    rd_mux = 32'h0;
    unique case (PADDR)
      OFS_CFG_ONE: rd_mux[2:0] = config_reg_one;
      OFS_CFG_TWO: rd_mux[1:0] = config_reg_two;
      OFS_EXT_ISC: begin
        rd_mux[ISC_MODE_BIT] = isc_mode_reg;
        rd_mux[ISC_MASK_BIT] = isc_mask_reg;
        rd_mux[ISC_FLAG_BIT] = ext_latched;
      end
      OFS_BRK_STAT: rd_mux[BRK_FLAG_BIT] = stop_wait_flag_reg;
      OFS_STATUS: rd_mux[2:0] = {pending_reg, 2'(state_reg)};
      default: rd_mux = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  ext_int_latch u_latch (
    .MCLK(MCLK),
    .RST(RST),
    .pin(EXT_INT_PIN_N),
    .enable(config_reg_two.ext_int_pin_enable), // RQ15
    .level_mode(isc_mode_reg), // RQ20
    .clear_vec(VECTOR_FETCH && pending_reg && vector_reg == VEC_TOP
        || pin_reset), // RQ17 RQ19
    .clear_sw(sw_ack), // RQ18
    .latched(ext_latched)
  );

  recovery_counter u_rec (
    .MCLK(MCLK),
    .RST(RST),
    .clear(state_reg != ST_RECOVER), // RQ14
    .short_sel(config_reg_one.short_stop_recovery_bit), // RQ12
    .done(rec_done)
  );

  // ----------------------------------------------------------------
  // Low-power sequencer
  // ----------------------------------------------------------------
  // Pin reset overrides every state; stack only on interrupt wakeups.
  always_comb begin
    state_next = state_reg;
    stack_next = 1'b0;
    unique case (state_reg)
      ST_RUN: begin
        if (STOP_REQ) begin
          state_next = ST_STOP; // RQ8
        end else if (WAIT_REQ) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (low_power_exit || emu_break) begin
          state_next = ST_RUN; // RQ4
          stack_next = (|sources) && !pin_reset;
        end
      end
      ST_STOP: begin
        if (pin_reset) begin
          state_next = ST_RUN; // RQ9
        end else if ((|sources) || BREAK_REQ) begin
          state_next = ST_RECOVER; // RQ9
        end
      end
      ST_RECOVER: begin
        if (pin_reset) begin
          state_next = ST_RUN;
        end else if (rec_done) begin
          state_next = ST_RUN;
          stack_next = int_cause_reg; // RQ10
        end
      end
    endcase
  end

  // State, wake cause and the sticky break flag.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_RUN;
      int_cause_reg <= 1'b0;
      stop_wait_flag_reg <= 1'b0;
    end else begin
      state_reg <= pin_reset ? ST_RUN : state_next;
      if (state_reg == ST_STOP) begin
        int_cause_reg <= |sources;
      end
      // Set wins over the software clear written in the same cycle.
      stop_wait_flag_reg <= (BREAK_REQ && (state_reg == ST_WAIT
          || state_reg == ST_STOP)) // RQ5
          || (stop_wait_flag_reg && !(apb_wr && PADDR == OFS_BRK_STAT
          && !PWDATA[BRK_FLAG_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // Clock generation and gating
  // ----------------------------------------------------------------
  // Dividers freeze low in stop and recovery; stop entry can cut a bus clock high phase to one cycle.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      half_reg <= 1'b0;
      bus_reg <= 1'b0;
    end else if (state_next == ST_STOP || state_next == ST_RECOVER) begin
      half_reg <= 1'b0; // RQ11
      bus_reg <= 1'b0;
    end else begin
      half_reg <= !half_reg; // RQ1
      bus_reg <= half_reg ? !bus_reg : bus_reg; // RQ1
    end
  end

  // Enables for the rest of the chip; watchdog ignores wait.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      fast_en_reg <= 1'b1;
      cpu_en_reg <= 1'b1;
      per_en_reg <= 1'b1;
      wdog_reg <= 1'b0;
      stack_reg <= 1'b0;
    end else begin
      fast_en_reg <= state_next != ST_STOP
          || config_reg_one.keep_osc_in_stop_bit; // RQ11
      cpu_en_reg <= state_next == ST_RUN; // RQ8
      per_en_reg <= state_next == ST_RUN || state_next == ST_WAIT;
      wdog_reg <= !config_reg_one.watchdog_disable_bit
          && state_next != ST_STOP && state_next != ST_RECOVER; // RQ6
      stack_reg <= stack_next && !pin_reset;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  // The acknowledge pulse names the source whose vector was fetched.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pending_reg <= 1'b0;
      vector_reg <= VEC_TOP;
      ack_reg <= '0;
    end else begin
      pending_reg <= |sources;
      vector_reg <= vec_of(win_idx); // RQ3
      ack_reg <= (VECTOR_FETCH && pending_reg)
          ? NUM_SOURCES'(1) << ((VEC_TOP - vector_reg) >> 1) : '0; // RQ3
    end
  end

  // ----------------------------------------------------------------
  // APB register slave
  // ----------------------------------------------------------------
  // One wait state: ready rises on the second access cycle.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= apb_rd_phase;
      pslverr_reg <= apb_rd_phase && !addr_ok;
      prdata_reg <= (apb_rd_phase && !PWRITE) ? rd_mux : 32'h0;
    end
  end

  // Configuration storage; pin functions stay ports out of reset.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      config_reg_one <= CFG1_RESET;
      config_reg_two <= CFG2_RESET; // RQ2
      isc_mode_reg <= 1'b0; // RQ20
      isc_mask_reg <= 1'b0;
    end else if (apb_wr) begin
      if (PADDR == OFS_CFG_ONE) begin
        config_reg_one <= PWDATA[2:0]; // RQ12
      end
      if (PADDR == OFS_CFG_TWO) begin
        config_reg_two <= PWDATA[1:0]; // RQ2 RQ15
      end
      if (PADDR == OFS_EXT_ISC) begin
        isc_mode_reg <= PWDATA[ISC_MODE_BIT];
        isc_mask_reg <= PWDATA[ISC_MASK_BIT];
      end
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign HALF_OSC_CLK = half_reg;
  assign BUS_CLK = bus_reg;
  assign FAST_OSC_EN = fast_en_reg;
  assign CPU_CLK_EN = cpu_en_reg;
  assign PERIPH_CLK_EN = per_en_reg;
  assign WDOG_EN = wdog_reg;
  assign STACK_START = stack_reg;
  assign INT_PENDING = pending_reg;
  assign INT_VECTOR = vector_reg;
  assign INT_ACK = ack_reg;
  assign RST_PIN_FUNC = config_reg_two.rst_pin_enable;
  assign EXT_INT_PIN_FUNC = config_reg_two.ext_int_pin_enable;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  bus_div_a: assert property (@(posedge MCLK) disable iff (RST) // RQ1
    $rose(bus_reg) |-> $past(half_reg) ##1
    (!$changed(bus_reg) || state_reg == ST_STOP))
    else $error("bus clock not a quarter of fast clock");
  wait_exit_a: assert property (@(posedge MCLK) disable iff (RST) // RQ4
    state_reg == ST_WAIT && (pin_reset || emu_break) |=> state_reg == ST_RUN)
    else $error("wait not left");
  brk_flag_a: assert property (@(posedge MCLK) disable iff (RST) // RQ5
    state_reg == ST_WAIT && BREAK_REQ |=> stop_wait_flag_reg)
    else $error("break flag not set in wait");
  wdog_wait_a: assert property (@(posedge MCLK) disable iff (RST) // RQ6
    state_reg == ST_WAIT && !config_reg_one.watchdog_disable_bit
    && $past(state_reg) == ST_WAIT |-> wdog_reg)
    else $error("watchdog stopped in wait");
  stop_clk_a: assert property (@(posedge MCLK) disable iff (RST) // RQ8
    state_reg == ST_STOP |-> !cpu_en_reg && !per_en_reg && !half_reg)
    else $error("clocks running in stop");
  stop_exit_a: assert property (@(posedge MCLK) disable iff (RST) // RQ9
    state_reg == ST_STOP && (|sources) && !pin_reset
    |=> state_reg == ST_RECOVER)
    else $error("stop not left on interrupt");
  stack_late_a: assert property (@(posedge MCLK) disable iff (RST) // RQ10
    $rose(stack_reg) && $past(state_reg) == ST_RECOVER |-> $past(rec_done))
    else $error("stacking before recovery end");
  fwd_mask_a: assert property (@(posedge MCLK) disable iff (RST) // RQ21
    isc_mask_reg && !(|PERIPH_IRQ) |=> !pending_reg)
    else $error("masked pin request forwarded");
endmodule

// ===== tb/cpu_model.sv
/*
  Behavioural CPU core that answers a pending interrupt with a vector fetch.
  Assumes it runs on the controller clock and sees its outputs directly.
*/
`timescale 1ns/100ps
module cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic fetch_en,
  input wire logic [3:0] lat,
  input wire logic int_pending,
  input wire logic cpu_clk_en,
  output logic vector_fetch
);
  logic [3:0] cnt_reg;
  logic go;
  // ------------------------------------------------------------------
  // Fetch sequencer
  // ------------------------------------------------------------------
  // The core fetches only while clocked. The latency stands for an
  // instruction that must finish first; the count saturates so that a
  // request that is slow to drop is not fetched twice.
  assign go = fetch_en && int_pending && cpu_clk_en;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      vector_fetch <= 1'h0;
    end else begin
      vector_fetch <= go && (cnt_reg == lat);
      if (!go) begin
        cnt_reg <= 4'h0;
      end else if (cnt_reg != 4'hF) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule

// ===== tb/test_system_sleep_and_ext_irq.sv
/*
  Self-checking bench of the sleep controller and its external interrupt.
  Assumes the package, the design files and the CPU model come first.
*/
`timescale 1ns/100ps
module test_system_sleep_and_ext_irq;
  import sleep_pkg::*;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic wait_req, stop_req, break_req, emu_mode, rst_pin_n, ext_pin_n;
  logic vector_fetch, fetch_en, half_clk, bus_clk, fast_en, cpu_en;
  logic periph_en, wdog_en, stack_start, int_pending, rst_func, int_func;
  logic [NUM_SOURCES-2:0] periph_irq;
  logic [15:0] int_vector;
  logic [NUM_SOURCES-1:0] int_ack;
  logic [3:0] lat;
  int fail_count = 0;
  int comparisons = 0;
  int stacks = 0;
  int acks = 0;
  // --------------------------------------------------------------------
  // Clock, design and CPU model
  // --------------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  sleep_ctrl dut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WAIT_REQ(wait_req),
    .STOP_REQ(stop_req), .BREAK_REQ(break_req), .EMU_MODE(emu_mode),
    .RST_PIN_N(rst_pin_n), .EXT_INT_PIN_N(ext_pin_n),
    .PERIPH_IRQ(periph_irq), .VECTOR_FETCH(vector_fetch),
    .HALF_OSC_CLK(half_clk), .BUS_CLK(bus_clk), .FAST_OSC_EN(fast_en),
    .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(periph_en), .WDOG_EN(wdog_en),
    .STACK_START(stack_start), .INT_PENDING(int_pending),
    .INT_VECTOR(int_vector), .INT_ACK(int_ack), .RST_PIN_FUNC(rst_func),
    .EXT_INT_PIN_FUNC(int_func));
  cpu_model cpu (.clk(mclk), .rst(rst), .fetch_en(fetch_en), .lat(lat),
    .int_pending(int_pending), .cpu_clk_en(cpu_en),
    .vector_fetch(vector_fetch));
  // Pulses are counted here so scenarios can check them long after.
  always @(posedge mclk) begin
    if (stack_start === 1'h1) stacks++;
    if (int_ack[0] === 1'h1) acks++;
  end
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    check("apb ready", pready, 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic pulse_wait();
    wait_req <= 1'h1;
    step(1);
    wait_req <= 1'h0;
    step(3);
  endtask
  task automatic pulse_break();
    break_req <= 1'h1;
    step(1);
    break_req <= 1'h0;
    step(4);
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    int hr = 0;
    int br = 0;
    logic h, b;
    check("pin funcs", {rst_func, int_func}, 2'h0);
    check("vector idle", int_vector, VEC_TOP);
    check("watchdog", wdog_en, 1'h1);
    for (int i = 0; i < 16; i++) begin
      h = half_clk;
      b = bus_clk;
      step(1);
      hr += (!h && half_clk);
      br += (!b && bus_clk);
    end
    check("half rises", hr, 8);
    check("bus rises", br, 4);
    apb(1'h0, OFS_EXT_ISC, 32'h0);
    check("latch reset", rd[ISC_FLAG_BIT], 1'h0);
  endtask
  task automatic t_regs();
    apb(1'h1, OFS_CFG_TWO, 32'h3);
    step(2);
    check("pin funcs on", {rst_func, int_func}, 2'h3);
    apb(1'h0, 8'h14, 32'h0);
    check("unmapped err", err, 1'h1);
    check("unmapped data", rd, 32'h0);
  endtask
  task automatic t_edge();
    apb(1'h1, OFS_CFG_TWO, 32'h0);
    ext_pin_n <= 1'h0;
    step(4);
    apb(1'h0, OFS_EXT_ISC, 32'h0);
    check("latch off", rd[ISC_FLAG_BIT], 1'h0);
    ext_pin_n <= 1'h1;
    apb(1'h1, OFS_CFG_TWO, 32'h1);
    ext_pin_n <= 1'h0;
    step(4);
    apb(1'h0, OFS_EXT_ISC, 32'h0);
    check("latch set", rd[ISC_FLAG_BIT], 1'h1);
    check("forwarded", int_pending, 1'h1);
    apb(1'h1, OFS_EXT_ISC, 32'h4);
    step(3);
    apb(1'h0, OFS_EXT_ISC, 32'h0);
    check("sw clear", rd[ISC_FLAG_BIT], 1'h0);
    apb(1'h1, OFS_EXT_ISC, 32'h1);
    step(3);
    apb(1'h0, OFS_EXT_ISC, 32'h0);
    check("level set", rd[ISC_FLAG_BIT], 1'h1);
    apb(1'h1, OFS_EXT_ISC, 32'h3);
    step(3);
    check("masked", int_pending, 1'h0);
    ext_pin_n <= 1'h1;
    apb(1'h1, OFS_EXT_ISC, 32'h4);
    fetch_en <= 1'h1;
    ext_pin_n <= 1'h0;
    step(14);
    check("vector ack", acks, 1);
    apb(1'h0, OFS_EXT_ISC, 32'h0);
    check("fetch clear", rd[ISC_FLAG_BIT], 1'h0);
    ext_pin_n <= 1'h1;
    fetch_en <= 1'h0;
  endtask
  task automatic t_vectors();
    for (int k = 0; k < NUM_SOURCES - 1; k++) begin
      periph_irq <= 23'h000001 << k;
      step(3);
      check("vector", int_vector, VEC_TOP - 16'(2 * (k + 1)));
      check("pending", int_pending, 1'h1);
    end
    periph_irq <= 23'h000088;
    step(3);
    check("priority", int_vector, VEC_TOP - 16'h0008);
    periph_irq <= 23'h000000;
  endtask
  task automatic t_wait();
    int s0;
    pulse_wait();
    check("wait cpu", cpu_en, 1'h0);
    check("wait dog", wdog_en, 1'h1);
    pulse_break();
    apb(1'h0, OFS_STATUS, 32'h0);
    check("wait held", rd[1:0], 2'h1);
    emu_mode <= 1'h1;
    pulse_break();
    apb(1'h0, OFS_STATUS, 32'h0);
    check("emu break exit", rd[1:0], 2'h0);
    apb(1'h0, OFS_BRK_STAT, 32'h0);
    check("break flag", rd[BRK_FLAG_BIT], 1'h1);
    emu_mode <= 1'h0;
    s0 = stacks;
    pulse_wait();
    periph_irq <= 23'h000004;
    step(6);
    check("irq exit", cpu_en, 1'h1);
    check("irq stack", stacks - s0, 1);
    periph_irq <= 23'h000000;
    apb(1'h1, OFS_CFG_ONE, 32'h2);
    apb(1'h1, OFS_CFG_TWO, 32'h3);
    apb(1'h1, OFS_EXT_ISC, 32'h2);
    ext_pin_n <= 1'h0;
    pulse_wait();
    check("dog off", wdog_en, 1'h0);
    rst_pin_n <= 1'h0;
    step(2);
    rst_pin_n <= 1'h1;
    step(3);
    check("pin exit", cpu_en, 1'h1);
    apb(1'h0, OFS_EXT_ISC, 32'h0);
    check("pin clears", rd[ISC_FLAG_BIT], 1'h0);
    ext_pin_n <= 1'h1;
  endtask
  task automatic t_stop(input logic [2:0] cfg, input int rec);
    int n = 0;
    logic h;
    apb(1'h1, OFS_CFG_ONE, {29'h0, cfg});
    stop_req <= 1'h1;
    step(1);
    stop_req <= 1'h0;
    step(2);
    check("stop en", {cpu_en, periph_en}, 2'h0);
    check("stop fast", fast_en, cfg[CFG1_OSCKEEP_BIT]);
    h = half_clk;
    step(60);
    check("stop half", half_clk, h);
    periph_irq <= 23'h000001;
    while (stack_start !== 1'h1 && n < 5000) begin
      step(1);
      n++;
    end
    check("recovery", n >= rec && n <= rec + 8, 1'h1);
    periph_irq <= 23'h000000;
  endtask
  task automatic t_stop_break();
    int s0;
    apb(1'h1, OFS_CFG_ONE, 32'h1);
    stop_req <= 1'h1;
    step(1);
    stop_req <= 1'h0;
    step(3);
    s0 = stacks;
    pulse_break();
    step(50);
    check("break wake", cpu_en, 1'h1);
    check("break no stack", stacks - s0, 0);
  endtask
  // --------------------------------------------------------------------
  // Sequence, verdict and watchdog
  // --------------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {rst, psel, penable, pwrite, wait_req, stop_req} = 6'h20;
    {break_req, emu_mode, fetch_en, rst_pin_n, ext_pin_n} = 5'h03;
    {paddr, pwdata, periph_irq, lat} = '0;
    lat = 4'h3;
    step(6);
    rst <= 1'h0;
    step(2);
    t_reset();
    t_regs();
    t_edge();
    t_vectors();
    t_wait();
    t_stop(3'h1, REC_SHORT_CYC);
    t_stop(3'h5, REC_SHORT_CYC);
    t_stop(3'h0, REC_LONG_CYC);
    t_stop_break();
    end_of_test();
  end
  // The whole run needs well under 10000 cycles.
  initial begin
    #300000;
    fail_count++;
    end_of_test();
  end
endmodule
